// *** rtl/pcs_top.sv ***
// program counter sequencer with holding latch and 8-level return stack
// assumes the decoder issues at most one operation per instruction clock
`timescale 1ns/1ps
module pcs_top #(
	parameter logic [12:0] INT_VECTOR = pcs_pkg::PCS_INT_VEC
) (
	input  wire logic                          clock_in,
	input  wire logic                          nrst_in,
	input  wire pcs_pkg::pcs_cmd_t             cmd_in,
	input  wire pcs_pkg::pcs_latch_wr_t        latch_wr_in,
	output logic      [pcs_pkg::PCS_PC_W-1:0]  pc_out,
	output logic      [pcs_pkg::PCS_LOW_W-1:0] pc_low_byte_reg_out,
	output logic      [pcs_pkg::PCS_LOW_W-1:0] pc_high_holding_latch_out
);

	// source of the next counter value, one bit per source
	typedef enum logic [5:0] {
		PCS_SRC_HOLD = 6'b000001,
		PCS_SRC_SEQ  = 6'b000010,
		PCS_SRC_LOW  = 6'b000100,
		PCS_SRC_PAGE = 6'b001000,
		PCS_SRC_POP  = 6'b010000,
		PCS_SRC_VEC  = 6'b100000
	} pcs_src_t;

	// stack action for this cycle; push and pop are exclusive by construction
	typedef enum logic [3:0] {
		PCS_STK_IDLE      = 4'b0001,
		PCS_STK_PUSH_NEXT = 4'b0010,
		PCS_STK_PUSH_HERE = 4'b0100,
		PCS_STK_POP       = 4'b1000
	} pcs_stk_t;

	pcs_pkg::pcs_core_t               core_q;
	pcs_pkg::pcs_core_t               core_d;
	logic                             push;
	logic                             pop;
	logic [pcs_pkg::PCS_PC_W-1:0]     push_data;
	logic [pcs_pkg::PCS_PC_W-1:0]     pop_data;
	logic [pcs_pkg::PCS_PC_W-1:0]     pc_next_seq;
	logic [pcs_pkg::PCS_PC_W-1:0]     low_wr_pc;
	logic [pcs_pkg::PCS_PC_W-1:0]     jump_pc;
	logic [pcs_pkg::PCS_UP_W-1:0]     latch_upper;
	logic [pcs_pkg::PCS_PAGE_W-1:0]   latch_page;
	// decoded command and the latch value for the next edge
	logic [pcs_pkg::PCS_LOW_W-1:0]    latch_next;
	pcs_src_t                         pc_src;
	pcs_stk_t                         stk_act;

	pcs_stack #(
		.WIDTH (pcs_pkg::PCS_PC_W),
		.DEPTH (pcs_pkg::PCS_DEPTH)
	) u_stack (
		.clock_in     (clock_in),
		.nrst_in      (nrst_in),
		.push_in      (push),
		.pop_in       (pop),
		.push_data_in (push_data),
		.pop_data_out (pop_data)
	);

	// latch fields used for page and upper-bit loads
	// bits 7..5 are never stored, so both views come from the low five
	assign latch_upper = core_q.latch[pcs_pkg::PCS_UP_W-1:0];
	assign latch_page  = core_q.latch[pcs_pkg::PCS_UP_W-1 -: pcs_pkg::PCS_PAGE_W];

	// full 13-bit sequential count
	// the top of the 8K space rolls over to address zero
	assign pc_next_seq = core_q.pc + pcs_pkg::PCS_PC_STEP;

	// no carry upward
	// the decoder hands over only the 8-bit sum, so a computed jump
	// that overflows the byte simply wraps within its 256-word block
	assign low_wr_pc = {latch_upper, cmd_in.data};

	// page from latch
	// only the two page bits join the opcode, latch bits 2..0 play no part
	assign jump_pc = {latch_page, cmd_in.target};

	// operation decode: each code picks a counter source and a stack action
	// splitting decode from the muxes keeps the stack and counter paths in step
	// unknown codes hold the counter and leave the stack alone
	always_comb
	begin
		pc_src  = PCS_SRC_HOLD;
		stk_act = PCS_STK_IDLE;
		case (cmd_in.op)
			// idle slot, nothing moves
			pcs_pkg::PCS_OP_NOP:
			begin
				pc_src  = PCS_SRC_HOLD;
				stk_act = PCS_STK_IDLE;
			end

			// plain advance to the next word
			pcs_pkg::PCS_OP_STEP:
			begin
				pc_src  = PCS_SRC_SEQ;
				stk_act = PCS_STK_IDLE;
			end

			pcs_pkg::PCS_OP_LOW_WR:
			begin
				pc_src  = PCS_SRC_LOW;
				stk_act = PCS_STK_IDLE;
			end

			// branch within the page held in the latch
			pcs_pkg::PCS_OP_JUMP:
			begin
				pc_src  = PCS_SRC_PAGE;
				stk_act = PCS_STK_IDLE;
			end

			pcs_pkg::PCS_OP_CALL:
			begin
				pc_src  = PCS_SRC_PAGE;
				stk_act = PCS_STK_PUSH_NEXT;
			end

			pcs_pkg::PCS_OP_RET:
			begin
				pc_src  = PCS_SRC_POP;
				stk_act = PCS_STK_POP;
			end

			// the literal itself is loaded into the working register elsewhere
			pcs_pkg::PCS_OP_RET_LIT:
			begin
				pc_src  = PCS_SRC_POP;
				stk_act = PCS_STK_POP;
			end

			// interrupt re-enable is handled by the interrupt logic
			pcs_pkg::PCS_OP_RET_INT:
			begin
				pc_src  = PCS_SRC_POP;
				stk_act = PCS_STK_POP;
			end

			// push on interrupt
			// the pending instruction is not executed, so its own address is saved
			pcs_pkg::PCS_OP_INTR:
			begin
				pc_src  = PCS_SRC_VEC;
				stk_act = PCS_STK_PUSH_HERE;
			end

			default:
			begin
				pc_src  = PCS_SRC_HOLD;
				stk_act = PCS_STK_IDLE;
			end
		endcase
	end

	// stack control: pointer and entries live in the stack block
	// a call saves the address after itself, an interrupt the one it preempts
	// push and pop never meet, since one action is decoded per cycle
	always_comb
	begin
		push      = 1'b0;
		pop       = 1'b0;
		push_data = pc_next_seq;
		case (stk_act)
			PCS_STK_IDLE:
			begin
				push = 1'b0;
				pop  = 1'b0;
			end

			PCS_STK_PUSH_NEXT:
			begin
				push      = 1'b1;
				push_data = pc_next_seq;
			end

			PCS_STK_PUSH_HERE:
			begin
				push      = 1'b1;
				push_data = core_q.pc;
			end

			PCS_STK_POP:
			begin
				pop = 1'b1;
			end

			default:
			begin
				push = 1'b0;
				pop  = 1'b0;
			end
		endcase
	end

	// latch only from software
	// stack traffic never reaches this path, so a return keeps the page bits
	// the unstored bits are masked off and read back as zero
	always_comb
	begin
		latch_next = core_q.latch;
		if (latch_wr_in.en)
		begin
			latch_next = latch_wr_in.data & pcs_pkg::PCS_LATCH_MSK;
		end
	end

	// next-state logic: one source feeds the counter each cycle
	// a latch write in the same cycle as a low write or branch only counts
	// from the next command, since addresses are built from the stored latch
	always_comb
	begin
		core_d       = core_q;
		core_d.latch = latch_next;
		case (pc_src)
			PCS_SRC_HOLD:
			begin
				core_d.pc = core_q.pc;
			end

			PCS_SRC_SEQ:
			begin
				core_d.pc = pc_next_seq;
			end

			PCS_SRC_LOW:
			begin
				core_d.pc = low_wr_pc;
			end

			PCS_SRC_PAGE:
			begin
				core_d.pc = jump_pc;
			end

			PCS_SRC_POP:
			begin
				core_d.pc = pop_data;
			end

			PCS_SRC_VEC:
			begin
				core_d.pc = INT_VECTOR;
			end

			default:
			begin
				core_d.pc = core_q.pc;
			end
		endcase
	end

	// reset clears counter
	// reset is asynchronous so the fetch address is safe before the clock runs;
	// the latch clears with it, so the first branch after reset lands in page 0
	// the stack block clears its own pointer and entries on the same reset
	always_ff @(posedge clock_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			core_q.pc    <= pcs_pkg::PCS_PC_RST;
			core_q.latch <= pcs_pkg::PCS_LATCH_RST;
		end
		else
		begin
			core_q <= core_d;
		end
	end

	// no stack status
	// upper pc bits leave only on the fetch address, never on a read path
	// fetch address for program memory
	assign pc_out                    = core_q.pc;
	// software read path of the low byte register
	assign pc_low_byte_reg_out       = core_q.pc[pcs_pkg::PCS_LOW_W-1:0];
	// latch read back, bits above the five stored ones are zero
	assign pc_high_holding_latch_out = core_q.latch;

endmodule : pcs_top

// *** rtl/pcs_pkg.sv ***
// program counter and return stack: shared constants and carrier types
// assumes one instruction-clock domain; all users reference pcs_pkg::name
package pcs_pkg;

	// widths of the address path
	localparam int PCS_PC_W   = 13;
	localparam int PCS_LOW_W  = 8;
	localparam int PCS_UP_W   = 5;
	localparam int PCS_JMP_W  = 11;
	localparam int PCS_PAGE_W = 2;
	localparam int PCS_DEPTH  = 8;

	// reset and fixed values
	localparam logic [12:0] PCS_PC_RST    = 13'h0000;
	localparam logic [12:0] PCS_PC_STEP   = 13'h0001;
	localparam logic [12:0] PCS_INT_VEC   = 13'h0004;
	localparam logic [7:0]  PCS_LATCH_RST = 8'h00;
	// only the five low latch bits exist, the rest read as zero
	localparam logic [7:0]  PCS_LATCH_MSK = 8'h1F;

	// operations issued by the instruction decoder, one per cycle
	typedef enum logic [3:0] {
		PCS_OP_NOP     = 4'h0,
		PCS_OP_STEP    = 4'h1,
		PCS_OP_LOW_WR  = 4'h2,
		PCS_OP_JUMP    = 4'h3,
		PCS_OP_CALL    = 4'h4,
		PCS_OP_RET     = 4'h5,
		PCS_OP_RET_LIT = 4'h6,
		PCS_OP_RET_INT = 4'h7,
		PCS_OP_INTR    = 4'h8
	} pcs_op_t;

	// decoder command: operation, opcode target, low byte write data
	typedef struct packed {
		pcs_op_t                op;
		logic [PCS_JMP_W-1:0]   target;
		logic [PCS_LOW_W-1:0]   data;
	} pcs_cmd_t;

	// write to the high-address holding latch
	typedef struct packed {
		logic                   en;
		logic [PCS_LOW_W-1:0]   data;
	} pcs_latch_wr_t;

	// counter and latch state of the sequencer; the stack keeps its own
	typedef struct packed {
		logic [PCS_PC_W-1:0]    pc;
		logic [PCS_LOW_W-1:0]   latch;
	} pcs_core_t;

endpackage : pcs_pkg

// *** rtl/pcs_stack.sv ***
// circular return-address stack built from flip-flops
// assumes push and pop never arrive in the same cycle; DEPTH a power of two
`timescale 1ns/1ps
module pcs_stack #(
	parameter int WIDTH = pcs_pkg::PCS_PC_W,
	parameter int DEPTH = pcs_pkg::PCS_DEPTH
) (
	input  wire logic             clock_in,
	input  wire logic             nrst_in,
	input  wire logic             push_in,
	input  wire logic             pop_in,
	input  wire logic [WIDTH-1:0] push_data_in,
	output logic      [WIDTH-1:0] pop_data_out
);

	localparam int PTR_W = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PTR_W-1:0]            ptr;
	} pcs_stack_state_t;

	pcs_stack_state_t state_q;
	pcs_stack_state_t state_d;

	// top entry sits just below the pointer; wraps, so an empty pop reads stale data
	assign pop_data_out = state_q.mem[PTR_W'(state_q.ptr - 1'b1)];

	// pointer wraps both ways, so there is nothing to flag on over or underflow
	always_comb
	begin
		state_d = state_q;
		if (push_in)
		begin
			state_d.mem[state_q.ptr] = push_data_in;
			state_d.ptr              = PTR_W'(state_q.ptr + 1'b1);
		end
		else if (pop_in)
		begin
			state_d.ptr = PTR_W'(state_q.ptr - 1'b1);
		end
	end

	// state register
	always_ff @(posedge clock_in or negedge nrst_in)
	begin
		if (!nrst_in)
			state_q <= '0;
		else
			state_q <= state_d;
	end

endmodule : pcs_stack

// *** sim/pcs_top_monitor.sv ***
// checker: pc sequencing relations at the sequencer ports
// assumes one clock domain, bound into every pcs_top
`timescale 1ns/1ps
module pcs_top_monitor #(
	parameter logic [12:0] INT_VECTOR = 13'h0004
) (
	input wire logic                   clock_in,
	input wire logic                   nrst_in,
	input wire pcs_pkg::pcs_cmd_t      cmd_in,
	input wire pcs_pkg::pcs_latch_wr_t latch_wr_in,
	input wire logic [12:0]            pc_out,
	input wire logic [7:0]             pc_low_byte_reg_out,
	input wire logic [7:0]             pc_high_holding_latch_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!nrst_in);
	// short views of the op, the five stored latch bits and the latch page bits
	wire pcs_pkg::pcs_op_t op = cmd_in.op;
	wire [4:0]             l5 = pc_high_holding_latch_out[4:0];
	wire [1:0]             l2 = pc_high_holding_latch_out[4:3];
	a_low_mirror: assert property (pc_low_byte_reg_out == pc_out[7:0])
		else $error("low byte differs from pc");
	a_low_load: assert property (op == pcs_pkg::PCS_OP_LOW_WR
		|=> pc_out == {$past(l5), $past(cmd_in.data)}) else $error("low write load wrong");
	a_page_jump: assert property (op inside {pcs_pkg::PCS_OP_JUMP, pcs_pkg::PCS_OP_CALL}
		|=> pc_out == {$past(l2), $past(cmd_in.target)}) else $error("jump page wrong");
	a_call_back: assert property (op == pcs_pkg::PCS_OP_CALL ##2 op inside {pcs_pkg::PCS_OP_RET,
		pcs_pkg::PCS_OP_RET_LIT, pcs_pkg::PCS_OP_RET_INT} |=> pc_out == $past(pc_out, 3) + 13'h1)
		else $error("return address wrong");
	a_intr_vec: assert property (op == pcs_pkg::PCS_OP_INTR |=> pc_out == INT_VECTOR)
		else $error("vector not taken");
	a_intr_back: assert property (op == pcs_pkg::PCS_OP_INTR ##2 op == pcs_pkg::PCS_OP_RET_INT
		|=> pc_out == $past(pc_out, 3)) else $error("interrupt return wrong");
	a_latch_keep: assert property (op inside {pcs_pkg::PCS_OP_CALL, pcs_pkg::PCS_OP_RET,
		pcs_pkg::PCS_OP_RET_LIT, pcs_pkg::PCS_OP_RET_INT, pcs_pkg::PCS_OP_INTR}
		&& !latch_wr_in.en |=> $stable(pc_high_holding_latch_out)) else $error("latch moved");
	a_step_wrap: assert property (op == pcs_pkg::PCS_OP_STEP
		|=> pc_out == $past(pc_out) + 13'h1) else $error("step wrong");
	// reset itself must be seen, so this one is never disabled
	a_reset_clear: assert property (disable iff (1'b0) !nrst_in |-> pc_out == 13'h0000)
		else $error("pc not cleared in reset");
endmodule : pcs_top_monitor
bind pcs_top pcs_top_monitor #(.INT_VECTOR(INT_VECTOR)) u_mon (.clock_in(clock_in),
	.nrst_in(nrst_in), .cmd_in(cmd_in), .latch_wr_in(latch_wr_in), .pc_out(pc_out),
	.pc_low_byte_reg_out(pc_low_byte_reg_out),
	.pc_high_holding_latch_out(pc_high_holding_latch_out));

// *** sim/pcs_dec_model.sv ***
// decoder stand-in: one command per instruction clock, idle between
// assumes the bench calls its tasks; drives on the falling edge
`timescale 1ns/1ps
module pcs_dec_model (
	input  wire logic              clock_in,
	output pcs_pkg::pcs_cmd_t      cmd_out,
	output pcs_pkg::pcs_latch_wr_t lwr_out
);
	// idle until told otherwise
	initial
	begin
		cmd_out = '0;
		lwr_out = '0;
	end
	// one op for one edge, then back to nop
	task automatic issue(input pcs_pkg::pcs_op_t o, input logic [10:0] t, input logic [7:0] d);
		@(negedge clock_in);
		cmd_out = '{o, t, d};
		@(negedge clock_in);
		cmd_out = '0;
	endtask : issue
	task automatic page(input logic [7:0] d);
		@(negedge clock_in);
		lwr_out = '{1'b1, d};
		@(negedge clock_in);
		lwr_out = '0;
	endtask : page
endmodule : pcs_dec_model

// *** sim/pcs_top_tb.sv ***
// bench: scenario tasks drive the sequencer through the decoder model
// assumes 100 MHz clock, inputs change on the falling edge
`timescale 1ns/1ps
module pcs_top_tb;
	logic                   clock_in;
	logic                   nrst_in;
	pcs_pkg::pcs_cmd_t      cmd;
	pcs_pkg::pcs_latch_wr_t lwr;
	logic [12:0]            pc;
	logic [7:0]             low;
	logic [7:0]             lat;
	int                     error_cnt = 0;
	int                     num_checks = 0;
	int                     cyc = 0;
	// free running instruction clock
	initial
	begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end
	pcs_dec_model dec (.clock_in(clock_in), .cmd_out(cmd), .lwr_out(lwr));
	pcs_top dut (.clock_in(clock_in), .nrst_in(nrst_in), .cmd_in(cmd), .latch_wr_in(lwr),
		.pc_out(pc), .pc_low_byte_reg_out(low), .pc_high_holding_latch_out(lat));
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [12:0] e, input logic [12:0] g);
		num_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("unexpected at %0t: exp %h got %h", $time, e, g);
		end
	endtask : chk
	// low write takes all five latch bits, step wraps at the top
	task automatic t_low();
		dec.page(8'hFF);
		chk(13'h001F, {5'h00, lat});
		dec.issue(pcs_pkg::PCS_OP_LOW_WR, 11'h000, 8'hFF);
		chk(13'h1FFF, pc);
		chk(13'h00FF, {5'h00, low});
		dec.issue(pcs_pkg::PCS_OP_STEP, 11'h000, 8'h00);
		chk(13'h0000, pc);
	endtask : t_low
	// cross-page call and return, then interrupt entry and return
	task automatic t_call();
		dec.page(8'h00);
		dec.issue(pcs_pkg::PCS_OP_JUMP, 11'h500, 8'h00);
		chk(13'h0500, pc);
		dec.page(8'h08);
		dec.issue(pcs_pkg::PCS_OP_CALL, 11'h100, 8'h00);
		chk(13'h0900, pc);
		dec.issue(pcs_pkg::PCS_OP_RET_LIT, 11'h000, 8'h00);
		chk(13'h0501, pc);
		chk(13'h0008, {5'h00, lat});
		dec.issue(pcs_pkg::PCS_OP_INTR, 11'h000, 8'h00);
		chk(13'h0004, pc);
		dec.issue(pcs_pkg::PCS_OP_RET_INT, 11'h000, 8'h00);
		chk(13'h0501, pc);
	endtask : t_call
	// nine calls overrun the stack; the first entry is lost for good
	task automatic t_wrap();
		pcs_pkg::pcs_op_t r[3];
		r = '{pcs_pkg::PCS_OP_RET, pcs_pkg::PCS_OP_RET_LIT, pcs_pkg::PCS_OP_RET_INT};
		dec.page(8'h00);
		for (int i = 1; i <= 9; i++)
			dec.issue(pcs_pkg::PCS_OP_CALL, 11'h100 + 11'(i), 8'h00);
		for (int k = 0; k <= 8; k++)
		begin
			dec.issue(r[k % 3], 11'h000, 8'h00);
			chk(13'h0109 - 13'(k % 8), pc);
		end
	endtask : t_wrap
	// mid-run reset clears upper pc bits and the latch
	task automatic t_rst();
		dec.page(8'h1F);
		@(negedge clock_in);
		nrst_in = 1'b0;
		@(negedge clock_in);
		chk(13'h0000, pc);
		chk(13'h0000, {5'h00, lat});
		nrst_in = 1'b1;
		// after release the count starts from zero and the stack comes back cleared
		dec.issue(pcs_pkg::PCS_OP_STEP, 11'h000, 8'h00);
		chk(13'h0001, pc);
		dec.issue(pcs_pkg::PCS_OP_RET, 11'h000, 8'h00);
		chk(13'h0000, pc);
	endtask : t_rst
	// main sequence after a 20-cycle reset
	initial
	begin
		nrst_in = 1'b0;
		repeat (20) @(negedge clock_in);
		nrst_in = 1'b1;
		t_low();
		t_call();
		t_wrap();
		t_rst();
		end_of_test();
	end
	// hang guard, far above the fewer than one hundred cycles needed
	always @(posedge clock_in)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			error_cnt++;
			end_of_test();
		end
	end
endmodule : pcs_top_tb
